// ==== logic/ccw_params.svh ====
// Constants for the CPU clock mode and wait control block
// Notes on behaviour
// - Source 0, divider 00b, force 0: CPU clock is main clock undivided.
// - Main clock divided by 2, 4, 16 per code; force bit gives 8.
// - Source 1 uses on-chip oscillator clock, same divisions, crystal bits ignored.
// - Low-speed oscillator when its stop bit and select are 0; high-speed when select and its enable are 1.
// - On-chip oscillator modes also feed the peripheral clock dividers.
// - Raw and divide-by-128 oscillator clocks available while the selected oscillator runs.
// - High-speed timer clock supplied only while high-speed enable is 1.
// - Low-speed safety clock supplied only while low-speed stop bit is 0.
// - Wait stops CPU clock and watchdog unless protection on; oscillators keep running.
// - Stop-in-wait bit 1 gates all peripheral clock taps during wait.
// - Sleep instruction enters wait mode.
// - All pins hold their pre-wait state during wait.
// - Reset or peripheral interrupt leaves wait; reset-only wake needs levels 000b.
// - Gated clocks allow only externally driven wake sources; A/D one-shot only.
// - Qualifying interrupt in wait restarts CPU clock, then interrupt sequence.
// - Interrupt wake resumes exactly the source and division used at sleep.
// - Flash activation 12 system clocks, plus up to 30 us if flash operates.
// - Then 6 CPU clocks to restart and 20 CPU clocks interrupt sequence.
// - After reset CPU clock is low-speed oscillator divided by 8.
// - Two-bit divider select honoured only while force bit is 0.
`ifndef CCW_PARAMS_SVH
`define CCW_PARAMS_SVH
`define CCW_ADDR_W 4
`define CCW_DATA_W 16
`define CCW_ADDR_CTRL 4'h0
`define CCW_ADDR_STATUS 4'h1
`define CCW_CTRL_RESET 16'h0029
`define CCW_B_SRC 0
`define CCW_B_DIV_LO 1
`define CCW_B_DIV_HI 2
`define CCW_B_DIV8 3
`define CCW_B_XTAL 4
`define CCW_B_MSTOP 5
`define CCW_B_LSTOP 6
`define CCW_B_HSOEN 7
`define CCW_B_OCOSEL 8
`define CCW_B_PSTOP 9
`define CCW_B_FSTOP 10
`define CCW_NSRC 9
`define CCW_WAKE_ALWAYS 9'h082
`define CCW_WAKE_COND 9'h049
`define CCW_ADC_SRC 2
`define CCW_FLASH_TICKS 12
`define CCW_RESTART_CYC 6
`define CCW_ISEQ_CYC 20
`define CCW_CLK_PERIOD_NS 50
`define CCW_FLASH_MAX_NS 30000
`define CCW_FLASH_MAX_CYC (`CCW_FLASH_MAX_NS / `CCW_CLK_PERIOD_NS)
`define CCW_WCNT_W 10
`endif

// ==== logic/ccw_pkg.sv ====
// Types for the CPU clock mode and wait control block
package ccw_pkg;
   typedef enum logic [4:0] {
      CCW_RUN = 5'h01,
      CCW_WAIT = 5'h02,
      CCW_FLASH = 5'h04,
      CCW_RESTART = 5'h08,
      CCW_ISEQ = 5'h10
   } ccw_state_t;
   typedef enum logic [2:0] {
      CCW_DIV1 = 3'h0,
      CCW_DIV2 = 3'h1,
      CCW_DIV4 = 3'h2,
      CCW_DIV8 = 3'h3,
      CCW_DIV16 = 3'h4
   } ccw_div_t;
endpackage

// ==== logic/ccw_top.sv ====
// CPU clock source, divider and wait mode control
//
// Our own choices: the plain strobed port and the placing of the registers.
`include "ccw_params.svh"
module ccw_top
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [`CCW_ADDR_W-1:0] addr,
   input wire logic [`CCW_DATA_W-1:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [`CCW_DATA_W-1:0] rdata,
   input wire logic main_osc_in,
   input wire logic lso_osc_in,
   input wire logic hso_osc_in,
   input wire logic sleep_exec,
   input wire logic [`CCW_NSRC-1:0] irq_req,
   input wire logic [`CCW_NSRC-1:0] irq_prio_nonzero,
   input wire logic [`CCW_NSRC-1:0] irq_ext_driven,
   input wire logic global_irq_en,
   input wire logic adc_one_shot,
   input wire logic csp_mode,
   output logic cpu_clk,
   output logic [4:0] periph_clk_taps,
   output logic oco_raw_clock,
   output logic oco_div128_clock,
   output logic hso_timer_clock,
   output logic lso_safety_clock,
   output logic wdt_run,
   output logic pin_hold,
   output logic wait_active,
   output logic irq_seq_busy,
   output logic irq_seq_done
);
   logic [`CCW_DATA_W-1:0] ctrl;
   logic sysclk_source_sel;
   logic [1:0] cpu_div_sel;
   logic div8_force;
   logic xtal_pin_enable;
   logic main_osc_stop;
   logic lso_stop;
   logic hso_enable;
   logic oco_select;
   logic periph_clk_stop_in_wait;
   logic flash_stop;
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [2:0] sync3;
   logic [2:0] filt;
   logic main_lvl;
   logic oco_lvl;
   logic oco_prev;
   logic oco_rise;
   logic act_sel;
   ccw_pkg::ccw_div_t act_div;
   ccw_pkg::ccw_div_t req_div;
   logic sys_lvl;
   logic sys_prev;
   logic sys_rise;
   logic req_src_lvl;
   logic [4:0] sys_cnt;
   logic [6:0] oco_cnt;
   logic act_lvl;
   logic act_prev;
   logic act_rise;
   logic req_lvl;
   ccw_pkg::ccw_state_t state;
   ccw_pkg::ccw_state_t next_state;
   logic [`CCW_WCNT_W-1:0] wk_cnt;
   logic [`CCW_WCNT_W-1:0] next_wk_cnt;
   logic flash_ticks_done;
   logic [`CCW_NSRC-1:0] wake_allowed;
   logic wake_q;
   logic run_gate;
   logic taps_gate;
   logic [`CCW_DATA_W-1:0] status;

   assign sysclk_source_sel = ctrl[`CCW_B_SRC];
   assign cpu_div_sel = ctrl[`CCW_B_DIV_HI:`CCW_B_DIV_LO];
   assign div8_force = ctrl[`CCW_B_DIV8];
   assign xtal_pin_enable = ctrl[`CCW_B_XTAL];
   assign main_osc_stop = ctrl[`CCW_B_MSTOP];
   assign lso_stop = ctrl[`CCW_B_LSTOP];
   assign hso_enable = ctrl[`CCW_B_HSOEN];
   assign oco_select = ctrl[`CCW_B_OCOSEL];
   assign periph_clk_stop_in_wait = ctrl[`CCW_B_PSTOP];
   assign flash_stop = ctrl[`CCW_B_FSTOP];

   // Control register; reset value selects low-speed oscillator divided by 8
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl <= `CCW_CTRL_RESET;
      end
      else if (wr_en && addr == `CCW_ADDR_CTRL)
      begin
         ctrl <= wdata;
      end
   end

   always_comb
   begin
      status = '0;
      status[4:0] = state;
      status[5] = act_sel;
      status[8:6] = act_div;
      status[9] = cpu_clk;
   end

   // Read data valid the cycle after the strobe only
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rdata <= '0;
      end
      else if (rd_en && addr == `CCW_ADDR_CTRL)
      begin
         rdata <= ctrl;
      end
      else if (rd_en && addr == `CCW_ADDR_STATUS)
      begin
         rdata <= status;
      end
      else
      begin
         rdata <= '0;
      end
   end

   // Oscillator pins: three stages, level taken once stages two and three agree
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         filt <= '0;
      end
      else
      begin
         sync1 <= {hso_osc_in, lso_osc_in, main_osc_in};
         sync2 <= sync1;
         sync3 <= sync2;
         for (int i = 0; i < 3; i++)
         begin
            if (sync2[i] == sync3[i])
            begin
               filt[i] <= sync3[i];
            end
         end
      end
   end

   // Crystal pins and stop bit only matter for the main clock path
   assign main_lvl = filt[0] & xtal_pin_enable & ~main_osc_stop;
   assign oco_lvl = oco_select ? (filt[2] & hso_enable) : (filt[1] & ~lso_stop);
   assign sys_lvl = act_sel ? oco_lvl : main_lvl;
   assign req_src_lvl = sysclk_source_sel ? oco_lvl : main_lvl;
   assign sys_rise = sys_lvl & ~sys_prev;
   assign oco_rise = oco_lvl & ~oco_prev;

   // Force bit overrides the two-bit select
   always_comb
   begin
      if (div8_force)
      begin
         req_div = ccw_pkg::CCW_DIV8;
      end
      else
      begin
         case (cpu_div_sel)
            2'h0: req_div = ccw_pkg::CCW_DIV1;
            2'h1: req_div = ccw_pkg::CCW_DIV2;
            2'h2: req_div = ccw_pkg::CCW_DIV4;
            default: req_div = ccw_pkg::CCW_DIV16;
         endcase
      end
   end

   function automatic logic div_level(input ccw_pkg::ccw_div_t d, input logic src,
                                      input logic [4:0] cnt);
      case (d)
         ccw_pkg::CCW_DIV1: div_level = src;
         ccw_pkg::CCW_DIV2: div_level = cnt[0];
         ccw_pkg::CCW_DIV4: div_level = cnt[1];
         ccw_pkg::CCW_DIV8: div_level = cnt[2];
         default: div_level = cnt[3];
      endcase
   endfunction

   assign act_lvl = div_level(act_div, sys_lvl, sys_cnt);
   assign req_lvl = div_level(req_div, req_src_lvl, sys_cnt);
   assign act_rise = act_lvl & ~act_prev;

   // Ripple counters on system and on-chip oscillator clock edges
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sys_prev <= 1'b0;
         sys_cnt <= '0;
         act_prev <= 1'b0;
      end
      else
      begin
         sys_prev <= sys_lvl;
         act_prev <= act_lvl;
         if (sys_rise)
         begin
            sys_cnt <= sys_cnt + 5'h01;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         oco_prev <= 1'b0;
         oco_cnt <= '0;
      end
      else
      begin
         oco_prev <= oco_lvl;
         if (oco_rise)
         begin
            oco_cnt <= oco_cnt + 7'h01;
         end
      end
   end

   // Switch only while both old and new clocks sit low, so no runt pulse.
   // Settings stay frozen from sleep until the wake sequence ends.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         act_sel <= 1'b1;
         act_div <= ccw_pkg::CCW_DIV8;
      end
      else if (state == ccw_pkg::CCW_RUN && !sleep_exec && !act_lvl && !req_lvl)
      begin
         act_sel <= sysclk_source_sel;
         act_div <= req_div;
      end
   end

   // Wake qualification depends on whether the taps keep running
   always_comb
   begin
      if (periph_clk_stop_in_wait)
      begin
         wake_allowed = `CCW_WAKE_ALWAYS | (irq_ext_driven & `CCW_WAKE_COND);
      end
      else
      begin
         wake_allowed = '1;
         wake_allowed[`CCW_ADC_SRC] = adc_one_shot;
      end
   end

   assign wake_q = global_irq_en && |(irq_req & irq_prio_nonzero & wake_allowed);

   // Wait and wake sequencing
   always_comb
   begin
      next_state = state;
      next_wk_cnt = wk_cnt;
      case (state)
         ccw_pkg::CCW_RUN:
         begin
            if (sleep_exec)
            begin
               next_state = ccw_pkg::CCW_WAIT;
            end
         end
         ccw_pkg::CCW_WAIT:
         begin
            if (wake_q)
            begin
               next_state = ccw_pkg::CCW_FLASH;
               next_wk_cnt = '0;
            end
         end
         ccw_pkg::CCW_FLASH:
         begin
            if (!flash_ticks_done)
            begin
               if (sys_rise)
               begin
                  if (wk_cnt == `CCW_WCNT_W'(`CCW_FLASH_TICKS - 1))
                  begin
                     next_wk_cnt = '0;
                     if (flash_stop)
                     begin
                        next_state = ccw_pkg::CCW_RESTART;
                     end
                  end
                  else
                  begin
                     next_wk_cnt = wk_cnt + `CCW_WCNT_W'(1);
                  end
               end
            end
            else if (wk_cnt == `CCW_WCNT_W'(`CCW_FLASH_MAX_CYC - 1))
            begin
               next_state = ccw_pkg::CCW_RESTART;
               next_wk_cnt = '0;
            end
            else
            begin
               next_wk_cnt = wk_cnt + `CCW_WCNT_W'(1);
            end
         end
         ccw_pkg::CCW_RESTART:
         begin
            if (act_rise)
            begin
               if (wk_cnt == `CCW_WCNT_W'(`CCW_RESTART_CYC - 1))
               begin
                  next_state = ccw_pkg::CCW_ISEQ;
                  next_wk_cnt = '0;
               end
               else
               begin
                  next_wk_cnt = wk_cnt + `CCW_WCNT_W'(1);
               end
            end
         end
         ccw_pkg::CCW_ISEQ:
         begin
            if (act_rise)
            begin
               if (wk_cnt == `CCW_WCNT_W'(`CCW_ISEQ_CYC - 1))
               begin
                  next_state = ccw_pkg::CCW_RUN;
                  next_wk_cnt = '0;
               end
               else
               begin
                  next_wk_cnt = wk_cnt + `CCW_WCNT_W'(1);
               end
            end
         end
         default:
         begin
            next_state = ccw_pkg::CCW_RUN;
            next_wk_cnt = '0;
         end
      endcase
   end

   // Hardware reset also leaves wait through srst
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state <= ccw_pkg::CCW_RUN;
         wk_cnt <= '0;
      end
      else
      begin
         state <= next_state;
         wk_cnt <= next_wk_cnt;
      end
   end

   // Second flash phase is the 30 us worst case, counted on the fast clock
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         flash_ticks_done <= 1'b0;
      end
      else if (state != ccw_pkg::CCW_FLASH)
      begin
         flash_ticks_done <= 1'b0;
      end
      else if (!flash_ticks_done && sys_rise && !flash_stop
               && wk_cnt == `CCW_WCNT_W'(`CCW_FLASH_TICKS - 1))
      begin
         flash_ticks_done <= 1'b1;
      end
   end

   // CPU clock runs in normal operation and during the interrupt sequence
   assign run_gate = (state == ccw_pkg::CCW_RUN) || (state == ccw_pkg::CCW_ISEQ);
   assign taps_gate = !(state == ccw_pkg::CCW_WAIT && periph_clk_stop_in_wait);

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cpu_clk <= 1'b0;
         periph_clk_taps <= '0;
         oco_raw_clock <= 1'b0;
         oco_div128_clock <= 1'b0;
         hso_timer_clock <= 1'b0;
         lso_safety_clock <= 1'b0;
      end
      else
      begin
         cpu_clk <= run_gate & act_lvl;
         if (taps_gate)
         begin
            periph_clk_taps <= {sys_cnt[4], sys_cnt[2], sys_cnt[1], sys_cnt[0], sys_lvl};
         end
         else
         begin
            periph_clk_taps <= '0;
         end
         oco_raw_clock <= oco_lvl & (~lso_stop | hso_enable);
         oco_div128_clock <= oco_cnt[6] & (~lso_stop | hso_enable);
         hso_timer_clock <= filt[2] & hso_enable;
         lso_safety_clock <= filt[1] & ~lso_stop;
      end
   end

   // Oscillators are untouched by wait; only CPU-side gates change
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wdt_run <= 1'b1;
         pin_hold <= 1'b0;
         wait_active <= 1'b0;
         irq_seq_busy <= 1'b0;
         irq_seq_done <= 1'b0;
      end
      else
      begin
         wdt_run <= run_gate | csp_mode;
         pin_hold <= next_state == ccw_pkg::CCW_WAIT;
         wait_active <= next_state != ccw_pkg::CCW_RUN;
         irq_seq_busy <= next_state == ccw_pkg::CCW_ISEQ;
         irq_seq_done <= state == ccw_pkg::CCW_ISEQ && next_state == ccw_pkg::CCW_RUN;
      end
   end

   a_sleep_enters: assert property (@(posedge clk) disable iff (srst)
      state == ccw_pkg::CCW_RUN && sleep_exec |=> state == ccw_pkg::CCW_WAIT)
      else $error("sleep did not enter wait");
   a_wait_cpu_stop: assert property (@(posedge clk) disable iff (srst)
      state == ccw_pkg::CCW_WAIT |=> !cpu_clk && (wdt_run == $past(csp_mode)))
      else $error("cpu clock or watchdog running in wait");
   a_wait_pin_hold: assert property (@(posedge clk) disable iff (srst)
      state == ccw_pkg::CCW_RUN && sleep_exec |=> pin_hold)
      else $error("pins not held in wait");
   a_taps_gated_wait: assert property (@(posedge clk) disable iff (srst)
      state == ccw_pkg::CCW_WAIT && periph_clk_stop_in_wait ##1 state == ccw_pkg::CCW_WAIT
      |=> periph_clk_taps == 5'h00)
      else $error("peripheral taps not gated");
   a_wake_to_flash: assert property (@(posedge clk) disable iff (srst)
      state == ccw_pkg::CCW_WAIT && wake_q |=> state == ccw_pkg::CCW_FLASH ##1 !cpu_clk)
      else $error("wake did not start flash activation");
   a_flash_stop_len: assert property (@(posedge clk) disable iff (srst)
      state == ccw_pkg::CCW_FLASH && !flash_ticks_done && sys_rise && flash_stop
      && wk_cnt == `CCW_WCNT_W'(`CCW_FLASH_TICKS - 1) |=> state == ccw_pkg::CCW_RESTART)
      else $error("flash activation length wrong");
   a_restart_len: assert property (@(posedge clk) disable iff (srst)
      state == ccw_pkg::CCW_RESTART && act_rise
      && wk_cnt == `CCW_WCNT_W'(`CCW_RESTART_CYC - 1) |=> irq_seq_busy)
      else $error("restart length wrong");
   a_iseq_len: assert property (@(posedge clk) disable iff (srst)
      state == ccw_pkg::CCW_ISEQ && act_rise
      && wk_cnt == `CCW_WCNT_W'(`CCW_ISEQ_CYC - 1) |=> irq_seq_done ##1 !irq_seq_done)
      else $error("interrupt sequence length wrong");
   a_freeze_setting: assert property (@(posedge clk) disable iff (srst)
      state != ccw_pkg::CCW_RUN |=> $stable(act_sel) && $stable(act_div))
      else $error("clock setting changed during wait");
   a_hso_timer_gate: assert property (@(posedge clk) disable iff (srst)
      !hso_enable |=> !hso_timer_clock)
      else $error("high-speed timer clock while disabled");
   a_lso_safety_gate: assert property (@(posedge clk) disable iff (srst)
      lso_stop |=> !lso_safety_clock)
      else $error("safety clock while oscillator stopped");
endmodule

// ==== tb/ccw_partner.sv ====
// Model of the oscillators and interrupt sources around the clock block
`include "ccw_params.svh"
module ccw_partner
(
   input wire logic clk,
   input wire logic fire,
   input wire logic [3:0] fire_idx,
   input wire logic ack,
   output logic main_osc,
   output logic lso_osc,
   output logic hso_osc,
   output logic [`CCW_NSRC-1:0] irq_req
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] n;
   // Oscillators run free and slow, so the input synchroniser sees every level
   initial
   begin
      n = 5'h00;
      irq_req = '0;
   end
   always @(posedge clk)
   begin
      n <= n + 5'h01;
   end
   assign main_osc = n[1];
   assign hso_osc = n[2];
   assign lso_osc = n[4];
   // A source keeps asking until an interrupt sequence has run, which clears every request
   always @(posedge clk)
   begin
      if (ack)
         irq_req <= '0;
      else if (fire)
         irq_req[fire_idx] <= 1'b1;
   end
endmodule

// ==== tb/ccw_tb_top.sv ====
// Self-checking bench for the CPU clock mode and wait control block
`include "ccw_params.svh"
module ccw_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, srst, wr_en, rd_en, sleep_exec, global_irq_en, adc_one_shot, csp_mode, fire;
   logic [`CCW_ADDR_W-1:0] addr;
   logic [`CCW_DATA_W-1:0] wdata, rdata, rv;
   logic main_osc_in, lso_osc_in, hso_osc_in, cpu_clk, oco_raw_clock, oco_div128_clock;
   logic hso_timer_clock, lso_safety_clock, wdt_run, pin_hold, wait_active;
   logic irq_seq_busy, irq_seq_done;
   logic [4:0] periph_clk_taps, mon;
   logic [3:0] fire_idx;
   logic [`CCW_NSRC-1:0] irq_req, irq_prio_nonzero, irq_ext_driven;
   int n_fail = 0;
   int comparisons = 0;
   int seed = 22;
   int r [5];
   assign mon = {lso_safety_clock, hso_timer_clock, oco_raw_clock, periph_clk_taps[0], cpu_clk};
   ccw_top ccw_top_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .main_osc_in(main_osc_in), .lso_osc_in(lso_osc_in),
      .hso_osc_in(hso_osc_in), .sleep_exec(sleep_exec), .irq_req(irq_req),
      .irq_prio_nonzero(irq_prio_nonzero), .irq_ext_driven(irq_ext_driven),
      .global_irq_en(global_irq_en), .adc_one_shot(adc_one_shot), .csp_mode(csp_mode),
      .cpu_clk(cpu_clk), .periph_clk_taps(periph_clk_taps), .oco_raw_clock(oco_raw_clock),
      .oco_div128_clock(oco_div128_clock), .hso_timer_clock(hso_timer_clock),
      .lso_safety_clock(lso_safety_clock), .wdt_run(wdt_run), .pin_hold(pin_hold),
      .wait_active(wait_active), .irq_seq_busy(irq_seq_busy), .irq_seq_done(irq_seq_done));
   ccw_partner ccw_partner_i (.clk(clk), .fire(fire), .fire_idx(fire_idx),
      .ack(irq_seq_done), .main_osc(main_osc_in), .lso_osc(lso_osc_in),
      .hso_osc(hso_osc_in), .irq_req(irq_req));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic wrap_up();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic near(input int v, input int e, input int tol);
      chk(16'((v >= e - tol) && (v <= e + tol)), 16'h0001);
   endtask
   task automatic timeout();
      n_fail++;
      $display("CHECK FAILED at %0t: wait limit reached", $time);
      wrap_up();
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask
   function automatic int divf(input logic [15:0] c);
      if (c[`CCW_B_DIV8])
         return 8;
      return (c[2:1] == 2'h3) ? 16 : (1 << c[2:1]);
   endfunction
   function automatic logic [15:0] stat(input logic [15:0] c);
      logic [2:0] d;
      d = c[3] ? 3'h3 : (c[2:1] == 2'h3) ? 3'h4 : {1'b0, c[2:1]};
      return {7'h00, d, c[0], 5'h01};
   endfunction
   // System clock period in clk cycles, as the partner makes the oscillators
   function automatic int per(input logic [15:0] c);
      if (!c[0])
         return 4;
      return (c[8] && c[7]) ? 8 : 32;
   endfunction
   // Settings change only at clock boundaries, so poll until the switch lands
   task automatic settle(input logic [15:0] c);
      int k;
      k = 0;
      rd(`CCW_ADDR_STATUS, rv);
      while ((rv & 16'h01FF) !== stat(c))
      begin
         k++;
         if (k > 300)
            timeout();
         rd(`CCW_ADDR_STATUS, rv);
      end
   endtask
   task automatic meas(input int n);
      logic [4:0] p;
      p = mon;
      foreach (r[k])
         r[k] = 0;
      repeat (n)
      begin
         @(posedge clk);
         for (int k = 0; k < 5; k++)
            if (mon[k] && !p[k])
               r[k]++;
         p = mon;
      end
   endtask
   task automatic pulse_fire(input int i);
      @(posedge clk);
      fire <= 1'b1;
      fire_idx <= 4'(i);
      @(posedge clk);
      fire <= 1'b0;
   endtask
   // Cycles until the interrupt sequence starts, CPU clock rises inside it
   task automatic wake_watch(output int lat, output int rises);
      logic p;
      int w;
      lat = 0;
      rises = 0;
      w = 0;
      p = cpu_clk;
      while (!irq_seq_done)
      begin
         @(posedge clk);
         #1;
         if (!irq_seq_busy && rises == 0)
            lat++;
         if (irq_seq_busy && cpu_clk && !p)
            rises++;
         p = cpu_clk;
         w++;
         if (w > 3000)
            timeout();
      end
   endtask
   initial
   begin
      logic [15:0] c;
      logic [3:0] tt;
      logic ps, fs, pr, ok;
      int i, lat, ri;
      srst = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = '0;
      wdata = '0;
      sleep_exec = 1'b0;
      fire = 1'b0;
      fire_idx = 4'h0;
      global_irq_en = 1'b1;
      adc_one_shot = 1'b0;
      csp_mode = 1'b0;
      irq_prio_nonzero = '0;
      irq_ext_driven = '0;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rd(`CCW_ADDR_CTRL, rv);
      chk(rv, `CCW_CTRL_RESET);
      rd(`CCW_ADDR_STATUS, rv);
      chk(rv & 16'h01FF, 16'h00E1);
      chk(16'(wdt_run), 16'h0001);
      wr(`CCW_ADDR_STATUS, 16'hFFFF);
      rd(4'hF, rv);
      chk(rv, 16'h0000);
      rd(`CCW_ADDR_STATUS, rv);
      chk(rv & 16'h01FF, 16'h00E1);
      meas(2048);
      near(r[0], 8, 1);
      // Every divider code and force setting, from both sources
      for (int t = 0; t < 16; t++)
      begin
         tt = 4'(t);
         c = 16'h0090 | {7'h00, 1'($random(seed)), 4'h0, tt[2:0], tt[3]};
         wr(`CCW_ADDR_CTRL, c);
         settle(c);
         meas(8 * per(c) * divf(c));
         near(r[0], 8, 1);
         near(r[1], 8 * divf(c), 1);
      end
      // Timer and safety clocks against the two oscillator enables
      for (int t = 0; t < 4; t++)
      begin
         tt = 4'(t);
         // Select follows the fast enable, so the oscillator in use runs except when the slow one is stopped and the fast one is off
         wr(`CCW_ADDR_CTRL, {7'h00, tt[1], tt[1], tt[0], 6'h10});
         repeat (8) @(posedge clk);
         meas(64);
         chk(16'(r[4] > 0), 16'(!tt[0]));
         chk(16'(r[3] > 0), 16'(tt[1]));
         chk(16'(r[2] > 0), 16'(!tt[0] || tt[1]));
         if (tt[1:0] == 2'h1)
            chk(16'(oco_div128_clock), 16'h0000);
      end
      // Sleep and wake, first trial is a refused source with taps gated
      for (int t = 0; t < 12; t++)
      begin
         i = (t == 0) ? 4 : (t == 1) ? 1 : {$random(seed)} % 9;
         ps = (t == 0) ? 1'b1 : 1'($random(seed));
         fs = (t < 2) ? 1'(t == 0) : 1'($random(seed));
         pr = (t == 0) ? 1'b1 : 1'($random(seed));
         c = 16'h0090 | {5'h00, fs, ps, 5'h00, 4'($random(seed)) & 4'hE};
         wr(`CCW_ADDR_CTRL, c);
         settle(c);
         irq_prio_nonzero <= 9'h002 | (9'(pr) << i);
         irq_ext_driven <= 9'($random(seed));
         adc_one_shot <= 1'($random(seed));
         csp_mode <= 1'($random(seed));
         global_irq_en <= (t < 2) ? 1'b1 : 1'($random(seed));
         @(posedge clk);
         sleep_exec <= 1'b1;
         @(posedge clk);
         sleep_exec <= 1'b0;
         // Skip the last running cycle so its clock edges are not counted
         repeat (2) @(posedge clk);
         meas(40);
         chk(16'(pin_hold), 16'h0001);
         chk(16'(wait_active), 16'h0001);
         chk(16'(wdt_run), 16'(csp_mode));
         chk(16'(r[0]), 16'h0000);
         chk(16'(r[2] > 0), 16'h0001);
         chk(16'(r[1] > 0), 16'(!ps));
         if (ps)
            chk(16'(periph_clk_taps), 16'h0000);
         ok = global_irq_en && (pr || i == 1) && (ps ? (i == 1 || i == 7
            || (irq_ext_driven[i] && (i == 0 || i == 3 || i == 6))) : (i != 2 || adc_one_shot));
         pulse_fire(i);
         if (!ok)
         begin
            repeat (60) @(posedge clk);
            chk(16'(wait_active), 16'h0001);
            global_irq_en <= 1'b1;
            pulse_fire(1);
         end
         wake_watch(lat, ri);
         if (ok)
            near(lat, 48 + 24 * divf(c) + (fs ? 0 : 600), 8 + 4 * divf(c));
         chk(16'(ri), 16'(20));
         rd(`CCW_ADDR_STATUS, rv);
         chk(rv & 16'h01FF, stat(c));
      end
      // Hardware reset also ends wait mode
      @(posedge clk);
      sleep_exec <= 1'b1;
      @(posedge clk);
      sleep_exec <= 1'b0;
      repeat (10) @(posedge clk);
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk(16'(wait_active), 16'h0000);
      rd(`CCW_ADDR_CTRL, rv);
      chk(rv, `CCW_CTRL_RESET);
      wrap_up();
   end
endmodule
